// >>> bench/cmd_host_model.sv
/*
 * Host side of the serial command link: frames register reads and
 * accepts response bytes with random stalls.
 * Assumes the caller waits for each answer before the next send.
 */
`timescale 1ns/1ns
`default_nettype none

module cmd_host_model
    import status_id_pkg::*;
(
    input wire logic clk_sys, // system clock
    output var status_id_pkg::byte_beat_s rx_byte, // command byte out
    output var logic tx_ready // accepts response
);
    // stalls now and then so held responses get exercised
    initial begin
        tx_ready = 1'b0;
        forever @(negedge clk_sys) tx_ready <= ($urandom_range(3) != 0);
    end

    // high addresses go out escaped, low bits only
    task automatic send(input logic [7:0] a);
        logic [7:0] fr[$];
        if (a[7]) fr = '{CMD_HEADER, CMD_SIZE_HIGH, CMD_ESCAPE, CMD_ESCAPE, a & ~ADDR_HIGH_BIT};
        else fr = '{CMD_HEADER, CMD_SIZE_LOW, CMD_ESCAPE, a};
        foreach (fr[i]) begin
            @(negedge clk_sys);
            rx_byte <= '{1'b1, fr[i]};
        end
        // released line shows no stale byte
        @(negedge clk_sys);
        rx_byte <= '{1'b0, ~fr[fr.size()-1]};
    endtask

    initial rx_byte = '0;
endmodule // cmd_host_model

`default_nettype wire

// >>> bench/status_identity_registers_props.sv
/*
 * Checker for the status and identity registers: answer timing, fault
 * notify line, ambient trigger and refresh strobe.
 * Sees only the top module's ports; attached by the bind at the foot.
 */
`timescale 1ns/1ns
`default_nettype none

module status_identity_registers_props
    import status_id_pkg::*;
#(
    parameter logic [7:0] FW_MAJOR = 8'h02 // firmware major
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire status_id_pkg::byte_beat_s rx_byte, // command byte
    input wire logic tx_ready, // host accepts
    input wire status_id_pkg::byte_beat_s tx_byte, // response byte
    input wire status_id_pkg::fault_events_s fault_events, // fault strobes
    input wire logic fault_notify_line, // pending fault
    input wire logic [7:0] hop_channel, // active channel
    input wire logic ambient_req, // measure request
    input wire logic [7:0] ambient_channel, // measured channel
    input wire logic nv_write_done, // write pulse
    input wire logic nvm_refresh, // refresh strobe
    input wire logic encryption_en // feature level
);
    // one domain, quiet while in reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // short-address read frame, bytes back to back
    sequence rd_s(logic [7:0] a);
        rx_byte.valid && rx_byte.data == CMD_HEADER ##1
        rx_byte.valid && rx_byte.data == CMD_SIZE_LOW ##1
        rx_byte.valid && rx_byte.data == CMD_ESCAPE ##1
        rx_byte.valid && rx_byte.data == a;
    endsequence
    // no fault strobe for three cycles
    sequence quiet_s;
        (fault_events == '0)[*3];
    endsequence

    answer_ack_a: assert property (
        rd_s(ADDR_PLATFORM_RELEASE) |-> ##[3:4] tx_byte.valid && tx_byte.data == RSP_ACK)
        else $error("ack missing after read frame");
    tx_hold_a: assert property (
        tx_byte.valid && !tx_ready |=> tx_byte.valid && $stable(tx_byte.data))
        else $error("response byte dropped before accept");
    tx_gap_a: assert property (tx_byte.valid && tx_ready |=> !tx_byte.valid)
        else $error("no idle cycle between response bytes");
    notify_set_a: assert property (fault_events != '0 |=> fault_notify_line)
        else $error("notify not raised by fault");
    notify_hold_a: assert property (
        !fault_notify_line && fault_events == '0 |=> !fault_notify_line)
        else $error("notify raised without fault");
    read_clear_a: assert property (
        rd_s(ADDR_FAULT_CODE) ##1 quiet_s |=> !fault_notify_line)
        else $error("fault read left notify high");
    amb_trigger_a: assert property (rd_s(ADDR_CHANNEL_LEVEL) |-> ##[1:3] ambient_req)
        else $error("ambient read did not start measurement");
    amb_pulse_a: assert property (ambient_req |=> !ambient_req)
        else $error("measurement request longer than one cycle");
    amb_channel_a: assert property (
        ambient_req |-> ambient_channel == $past(hop_channel))
        else $error("measured channel is not the active one");
    refresh_cause_a: assert property (
        nvm_refresh |-> $past(nv_write_done) || $past(nv_write_done, 2))
        else $error("refresh without a preceding write");
    crypto_level_a: assert property (
        $past(rst_b) |-> encryption_en == (FW_MAJOR >= CRYPTO_MIN_MAJOR))
        else $error("encryption level wrong for major byte");
endmodule // status_identity_registers_props

bind status_identity_registers status_identity_registers_props #(.FW_MAJOR(FW_MAJOR)) props_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .rx_byte(rx_byte), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .fault_events(fault_events), .fault_notify_line(fault_notify_line),
    .hop_channel(hop_channel), .ambient_req(ambient_req), .ambient_channel(ambient_channel),
    .nv_write_done(nv_write_done), .nvm_refresh(nvm_refresh), .encryption_en(encryption_en)
);

`default_nettype wire

// >>> bench/tb.sv
/*
 * Self-checking bench for the status and identity registers.
 * The host model frames reads; this module plays radio, fault
 * sources and the non-volatile store, and checks every answer byte.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin $display("[FAIL] %s expected %h seen %h", n, e, g); bad_count++; end end

module tb;
    import status_id_pkg::*;
    logic clk_sys, rst_b, tx_ready, fault_notify_line, pkt_delivered, ambient_req;
    logic ambient_valid, nv_write_done, nvm_refresh, encryption_en;
    byte_beat_s rx_byte, tx_byte;
    fault_events_s fault_events;
    logic [7:0] pkt_level, hop_channel, ambient_channel, ambient_level, nv_write_limit;
    logic [7:0] amb_lvl, pkt, e_byte;
    logic [7:0] exp_q[$];
    int bad_count, checks_done, amb_wait, refreshes;
    // codes in event bit order, serial overflow first
    logic [7:0] fcodes[8] = '{FAULT_SERIAL_OVERFLOW, FAULT_RADIO_OVERFLOW,
        FAULT_REGISTER_WRITE, FAULT_MISSING_ACK, FAULT_PAYLOAD_CRC,
        FAULT_HEADER_CRC, FAULT_SEQUENCE_MISMATCH, FAULT_FRAME_TYPE};

    cmd_host_model host (.clk_sys(clk_sys), .rx_byte(rx_byte), .tx_ready(tx_ready));

    status_identity_registers dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .rx_byte(rx_byte), .tx_ready(tx_ready),
        .tx_byte(tx_byte), .fault_events(fault_events), .fault_notify_line(fault_notify_line),
        .pkt_delivered(pkt_delivered), .pkt_level(pkt_level), .hop_channel(hop_channel),
        .ambient_req(ambient_req), .ambient_channel(ambient_channel),
        .ambient_valid(ambient_valid), .ambient_level(ambient_level),
        .nv_write_done(nv_write_done), .nv_write_limit(nv_write_limit),
        .nvm_refresh(nvm_refresh), .encryption_en(encryption_en)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // radio answers after a random delay; level is junk outside the pulse
    always @(negedge clk_sys) begin
        ambient_valid <= (amb_wait == 1);
        if (ambient_req) amb_wait <= 2 + $urandom_range(5);
        else if (amb_wait != 0) amb_wait <= amb_wait - 1;
    end
    assign ambient_level = ambient_valid ? amb_lvl : ~amb_lvl;

    // each accepted answer byte against the oldest note
    always @(posedge clk_sys) begin
        if (rst_b && nvm_refresh) refreshes++;
        if (rst_b && tx_byte.valid && tx_ready) begin
            e_byte = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
            `CHK("tx_byte", e_byte, tx_byte.data)
        end
    end

    task automatic final_report;
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // one read; bounded wait for the whole answer
    task automatic rd(input logic [7:0] a, input logic [7:0] v, input bit ok);
        int n;
        n = 0;
        if (ok) exp_q = '{RSP_ACK, a, v};
        else exp_q = '{RSP_NACK};
        host.send(a);
        while (exp_q.size() != 0 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        if (exp_q.size() != 0) begin
            bad_count++;
            final_report();
        end
        repeat (2) @(negedge clk_sys);
    endtask

    // the host here reads the single code register, not the flag registers
    task automatic fault(input fault_events_s f);
        @(negedge clk_sys);
        fault_events <= f;
        @(negedge clk_sys);
        fault_events <= '0;
    endtask

    // each pulse stands for one host write, issued in ascending address order
    task automatic nvw(input logic [7:0] lim, input int n);
        nv_write_limit = lim;
        repeat (n) begin
            @(negedge clk_sys);
            nv_write_done <= 1'b1;
            @(negedge clk_sys);
            nv_write_done <= 1'b0;
        end
        repeat (3) @(negedge clk_sys);
    endtask

    initial begin
        void'($urandom(32'h1CDB));
        rst_b = 1'b0;
        fault_events = '0;
        pkt_delivered = 1'b0;
        pkt_level = 8'h00;
        hop_channel = 8'h00;
        ambient_valid = 1'b0;
        amb_lvl = 8'h00;
        amb_wait = 0;
        nv_write_done = 1'b0;
        nv_write_limit = NV_WRITES_MIN;
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        // reset contents and identity bytes
        rd(ADDR_PLATFORM_RELEASE, 8'h20, 1);
        rd(ADDR_FAULT_CODE, FAULT_NONE, 1);
        rd(ADDR_LAST_PACKET_LEVEL, RESET_LEVEL, 1);
        for (int i = 0; i < 4; i++) rd(ADDR_FW_MAJOR + 8'(i), (i == 0) ? 8'h02 : 8'h00, 1);
        rd(ADDR_REFRESH_HIGH, 8'h00, 1);
        rd(8'h7A, 8'h00, 0);
        `CHK("crypto", 1'b1, encryption_en)
        // every code, each cleared by its own read
        for (int i = 0; i < 8; i++) begin
            fault(fault_events_s'(8'h01 << i));
            `CHK("notify", 1'b1, fault_notify_line)
            rd(ADDR_FAULT_CODE, fcodes[i], 1);
            `CHK("notify", 1'b0, fault_notify_line)
        end
        fault(fault_events_s'(8'h01));
        fault(fault_events_s'(8'h80));
        rd(ADDR_FAULT_CODE, FAULT_FRAME_TYPE, 1);
        // only the latest delivery is kept, reads leave it alone
        repeat (2) begin
            pkt = 8'($urandom);
            @(negedge clk_sys);
            pkt_level <= pkt;
            pkt_delivered <= 1'b1;
            @(negedge clk_sys);
            pkt_delivered <= 1'b0;
            pkt_level <= ~pkt;
        end
        rd(ADDR_LAST_PACKET_LEVEL, pkt, 1);
        rd(ADDR_LAST_PACKET_LEVEL, pkt, 1);
        // fresh measurement per read, channel moves between reads
        repeat (3) begin
            amb_lvl = 8'($urandom);
            hop_channel = 8'($urandom);
            rd(ADDR_CHANNEL_LEVEL, amb_lvl, 1);
        end
        // refresh at both ends of the write allowance
        nvw(NV_WRITES_MIN, 8);
        `CHK("refreshes", 1, refreshes)
        rd(ADDR_REFRESH_LOW, 8'h01, 1);
        nvw(NV_WRITES_MAX, 149);
        `CHK("refreshes", 1, refreshes)
        nvw(NV_WRITES_MAX, 1);
        rd(ADDR_REFRESH_LOW, 8'h02, 1);
        rd(ADDR_REFRESH_HIGH, 8'h00, 1);
        final_report();
    end
endmodule // tb

`default_nettype wire

// >>> verilog/status_id_pkg.sv
/*
 * Shared constants and types for the status and identity register block:
 * command framing bytes, register addresses, fault codes, reset values.
 * Assumes a byte-wide serial command path already deframed from the UART.
 */
`default_nettype none

package status_id_pkg;

    // command framing
    localparam logic [7:0] CMD_HEADER = 8'hFF;
    localparam logic [7:0] CMD_ESCAPE = 8'hFE;
    localparam logic [7:0] CMD_SIZE_LOW = 8'h02;
    localparam logic [7:0] CMD_SIZE_HIGH = 8'h03;
    localparam logic [7:0] ADDR_HIGH_BIT = 8'h80;
    localparam logic [7:0] RSP_ACK = 8'h06;
    localparam logic [7:0] RSP_NACK = 8'h15;
    localparam logic [1:0] RSP_LAST_IDX = 2'h2;

    // register addresses
    localparam logic [7:0] ADDR_PLATFORM_RELEASE = 8'h78;
    localparam logic [7:0] ADDR_FAULT_CODE = 8'h79;
    localparam logic [7:0] ADDR_LAST_PACKET_LEVEL = 8'h7B;
    localparam logic [7:0] ADDR_CHANNEL_LEVEL = 8'h7C;
    localparam logic [7:0] ADDR_FW_MAJOR = 8'hC0;
    localparam logic [7:0] ADDR_FW_MINOR = 8'hC1;
    localparam logic [7:0] ADDR_FW_INCREMENTAL = 8'hC2;
    localparam logic [7:0] ADDR_FW_SUFFIX = 8'hC3;
    localparam logic [7:0] ADDR_REFRESH_HIGH = 8'hC4;
    localparam logic [7:0] ADDR_REFRESH_LOW = 8'hC5;

    // fault codes
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [7:0] FAULT_SERIAL_OVERFLOW = 8'h08;
    localparam logic [7:0] FAULT_RADIO_OVERFLOW = 8'h09;
    localparam logic [7:0] FAULT_REGISTER_WRITE = 8'h13;
    localparam logic [7:0] FAULT_MISSING_ACK = 8'h20;
    localparam logic [7:0] FAULT_PAYLOAD_CRC = 8'h40;
    localparam logic [7:0] FAULT_HEADER_CRC = 8'h42;
    localparam logic [7:0] FAULT_SEQUENCE_MISMATCH = 8'h43;
    localparam logic [7:0] FAULT_FRAME_TYPE = 8'h44;

    // feature thresholds
    localparam logic [7:0] FW_DETAIL_MIN_RELEASE = 8'h20;
    localparam logic [7:0] CRYPTO_MIN_MAJOR = 8'h02;
    localparam logic [7:0] NV_WRITES_MIN = 8'h08;
    localparam logic [7:0] NV_WRITES_MAX = 8'h96;

    // reset values and timing
    localparam logic [7:0] RESET_LEVEL = 8'h80;
    localparam logic [15:0] RESET_REFRESH_COUNT = 16'h0000;
    localparam logic [7:0] AMBIENT_TIMEOUT_CYCLES = 8'hFF;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_s;

    typedef struct packed {
        logic frame_type;
        logic sequence_mismatch;
        logic header_crc;
        logic payload_crc;
        logic missing_ack;
        logic register_write;
        logic radio_overflow;
        logic serial_overflow;
    } fault_events_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SIZE = 3'b001,
        ST_ESCAPE = 3'b010,
        ST_ADDR = 3'b011,
        ST_DECODE = 3'b100,
        ST_MEASURE = 3'b101,
        ST_RESPOND = 3'b110
    } cmd_state_e;

endpackage

`default_nettype wire

// >>> verilog/status_identity_registers.sv
/*
 * Status and identity registers behind the serial read-command path:
 * platform release, fault code with notify line, signal levels,
 * firmware revision bytes and the non-volatile refresh counter.
 * Assumes received command bytes arrive deframed, one beat per cycle,
 * synchronous to clk_sys; a measurement the radio never answers ends in a NACK.
 */
`timescale 1ns/1ns
`default_nettype none

module status_identity_registers #(
    parameter logic [7:0] RELEASE_CODE = 8'h20, // platform release byte
    parameter logic [7:0] FW_MAJOR = 8'h02, // firmware major
    parameter logic [7:0] FW_MINOR = 8'h00, // firmware minor
    parameter logic [7:0] FW_INCREMENTAL = 8'h00, // firmware incremental
    parameter logic [7:0] FW_SUFFIX = 8'h00 // firmware suffix
) (
    input wire logic clk_sys, // system clock, 20 MHz
    input wire logic rst_b, // async reset, active low
    input wire status_id_pkg::byte_beat_s rx_byte, // command byte from host
    input wire logic tx_ready, // host accepts tx_byte
    output status_id_pkg::byte_beat_s tx_byte, // response byte to host
    input wire status_id_pkg::fault_events_s fault_events, // fault strobes
    output logic fault_notify_line, // pending fault indicator
    input wire logic pkt_delivered, // packet payload sent to host
    input wire logic [7:0] pkt_level, // level of that packet, dBm
    input wire logic [7:0] hop_channel, // active hop channel
    output logic ambient_req, // start ambient measurement
    output logic [7:0] ambient_channel, // channel to measure
    input wire logic ambient_valid, // measurement result ready
    input wire logic [7:0] ambient_level, // measured level, dBm
    input wire logic nv_write_done, // one non-volatile write done
    input wire logic [7:0] nv_write_limit, // writes allowed per refresh
    output logic nvm_refresh, // refresh cycle strobe
    output logic encryption_en // encryption feature present
);
    import status_id_pkg::*;

    cmd_state_e state_q, state_d;
    logic [1:0] esc_left_q, esc_left_d;
    logic high_addr_q, high_addr_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] value_q, value_d;
    logic ack_q, ack_d;
    logic [1:0] rsp_idx_q, rsp_idx_d;
    logic [7:0] wait_q, wait_d;
    byte_beat_s tx_q, tx_d;
    logic ambient_req_q;
    logic [7:0] ambient_channel_q;
    logic [7:0] fault_code_q, fault_code_d;
    logic notify_q, notify_d;
    logic [7:0] last_level_q;
    logic [15:0] refresh_count_q, refresh_count_d;
    logic [7:0] nv_writes_q, nv_writes_d;
    logic refresh_q;
    logic crypto_q;

    // address decode of the latched read address
    wire logic fw_detail_ok = RELEASE_CODE >= FW_DETAIL_MIN_RELEASE;
    wire logic hit_release = addr_q == ADDR_PLATFORM_RELEASE;
    wire logic hit_fault = addr_q == ADDR_FAULT_CODE;
    wire logic hit_last = addr_q == ADDR_LAST_PACKET_LEVEL;
    wire logic hit_ambient = addr_q == ADDR_CHANNEL_LEVEL;
    wire logic hit_fw_major = fw_detail_ok && (addr_q == ADDR_FW_MAJOR);
    wire logic hit_fw_minor = fw_detail_ok && (addr_q == ADDR_FW_MINOR);
    wire logic hit_fw_inc = fw_detail_ok && (addr_q == ADDR_FW_INCREMENTAL);
    wire logic hit_fw_suffix = fw_detail_ok && (addr_q == ADDR_FW_SUFFIX);
    wire logic hit_ref_high = addr_q == ADDR_REFRESH_HIGH;
    wire logic hit_ref_low = addr_q == ADDR_REFRESH_LOW;
    wire logic hit_fw = hit_fw_major | hit_fw_minor | hit_fw_inc | hit_fw_suffix;
    wire logic hit_any = hit_release | hit_fault | hit_last | hit_fw
                       | hit_ref_high | hit_ref_low;

    // read data mux; every path is side-effect free except the fault code clear on a fault code read
    wire logic [7:0] read_data =
        hit_release ? RELEASE_CODE :
        hit_fault ? fault_code_q :
        hit_last ? last_level_q :
        hit_fw_major ? FW_MAJOR :
        hit_fw_minor ? FW_MINOR :
        hit_fw_inc ? FW_INCREMENTAL :
        hit_fw_suffix ? FW_SUFFIX :
        hit_ref_high ? refresh_count_q[15:8] :
        hit_ref_low ? refresh_count_q[7:0] :
        8'h00;

    // framing helpers
    wire logic rx_header = rx_byte.valid && (rx_byte.data == CMD_HEADER);
    wire logic rx_escape = rx_byte.valid && (rx_byte.data == CMD_ESCAPE);
    wire logic decode_now = state_q == ST_DECODE;
    wire logic read_fault = decode_now && hit_fault;
    wire logic start_measure = decode_now && hit_ambient;
    wire logic tx_done = tx_q.valid && tx_ready;
    wire logic rsp_last = !ack_q || (rsp_idx_q == RSP_LAST_IDX);

    // response byte selected by position in the answer
    wire logic [7:0] rsp_byte =
        !ack_q ? RSP_NACK :
        (rsp_idx_q == 2'h0) ? RSP_ACK :
        (rsp_idx_q == 2'h1) ? addr_q :
        value_q;

    // command parser and responder; bytes arriving mid-answer are dropped,
    // the link is treated as half duplex
    always_comb begin
        state_d = state_q;
        esc_left_d = esc_left_q;
        high_addr_d = high_addr_q;
        addr_d = addr_q;
        value_d = value_q;
        ack_d = ack_q;
        rsp_idx_d = rsp_idx_q;
        wait_d = wait_q;
        tx_d = tx_q;
        unique case (state_q)
            ST_IDLE: begin
                if (rx_header) begin
                    state_d = ST_SIZE;
                end
            end
            ST_SIZE: begin
                if (rx_byte.valid) begin
                    if (rx_byte.data == CMD_SIZE_LOW) begin
                        esc_left_d = 2'h1;
                        high_addr_d = 1'b0;
                        state_d = ST_ESCAPE;
                    end else if (rx_byte.data == CMD_SIZE_HIGH) begin
                        // second escape lifts the address into the upper half
                        esc_left_d = 2'h2;
                        high_addr_d = 1'b1;
                        state_d = ST_ESCAPE;
                    end else if (!rx_header) begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_ESCAPE: begin
                if (rx_escape) begin
                    esc_left_d = esc_left_q - 2'h1;
                    if (esc_left_q == 2'h1) begin
                        state_d = ST_ADDR;
                    end
                end else if (rx_header) begin
                    state_d = ST_SIZE; // resync on a fresh header
                end else if (rx_byte.valid) begin
                    state_d = ST_IDLE;
                end
            end
            ST_ADDR: begin
                if (rx_byte.valid) begin
                    addr_d = high_addr_q ? (rx_byte.data | ADDR_HIGH_BIT) : rx_byte.data;
                    state_d = ST_DECODE;
                end
            end
            ST_DECODE: begin
                rsp_idx_d = 2'h0;
                tx_d.valid = 1'b0;
                if (hit_ambient) begin
                    wait_d = AMBIENT_TIMEOUT_CYCLES;
                    state_d = ST_MEASURE;
                end else begin
                    value_d = read_data;
                    ack_d = hit_any;
                    state_d = ST_RESPOND;
                end
            end
            ST_MEASURE: begin
                // a silent radio would otherwise hang the command path
                wait_d = wait_q - 8'h01;
                if (ambient_valid) begin
                    value_d = ambient_level;
                    ack_d = 1'b1;
                    state_d = ST_RESPOND;
                end else if (wait_q == 8'h00) begin
                    ack_d = 1'b0;
                    state_d = ST_RESPOND;
                end
            end
            ST_RESPOND: begin
                if (!tx_q.valid) begin
                    tx_d.valid = 1'b1;
                    tx_d.data = rsp_byte;
                end else if (tx_done) begin
                    tx_d.valid = 1'b0;
                    rsp_idx_d = rsp_idx_q + 2'h1;
                    if (rsp_last) begin
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                tx_d.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            esc_left_q <= 2'h0;
            high_addr_q <= 1'b0;
            addr_q <= 8'h00;
            value_q <= 8'h00;
            ack_q <= 1'b0;
            rsp_idx_q <= 2'h0;
            wait_q <= 8'h00;
            tx_q <= '0;
        end else begin
            state_q <= state_d;
            esc_left_q <= esc_left_d;
            high_addr_q <= high_addr_d;
            addr_q <= addr_d;
            value_q <= value_d;
            ack_q <= ack_d;
            rsp_idx_q <= rsp_idx_d;
            wait_q <= wait_d;
            tx_q <= tx_d;
        end
    end

    // ambient request strobe samples the channel active at that moment
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ambient_req_q <= 1'b0;
            ambient_channel_q <= 8'h00;
        end else begin
            ambient_req_q <= start_measure;
            if (start_measure) begin
                ambient_channel_q <= hop_channel;
            end
        end
    end

    // fault source priority: lowest code wins when several fire together
    wire logic fault_hit = |fault_events;
    wire logic [7:0] fault_new =
        fault_events.serial_overflow ? FAULT_SERIAL_OVERFLOW :
        fault_events.radio_overflow ? FAULT_RADIO_OVERFLOW :
        fault_events.register_write ? FAULT_REGISTER_WRITE :
        fault_events.missing_ack ? FAULT_MISSING_ACK :
        fault_events.payload_crc ? FAULT_PAYLOAD_CRC :
        fault_events.header_crc ? FAULT_HEADER_CRC :
        fault_events.sequence_mismatch ? FAULT_SEQUENCE_MISMATCH :
        FAULT_FRAME_TYPE;

    // a fault in the same cycle as the clearing read survives the clear
    assign fault_code_d = fault_hit ? fault_new :
                          read_fault ? FAULT_NONE :
                          fault_code_q;
    assign notify_d = fault_hit | (notify_q & ~read_fault);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fault_code_q <= FAULT_NONE;
            notify_q <= 1'b0;
        end else begin
            fault_code_q <= fault_code_d;
            notify_q <= notify_d;
        end
    end

    // last delivered packet level, overwritten on every delivery
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            last_level_q <= RESET_LEVEL;
        end else if (pkt_delivered) begin
            last_level_q <= pkt_level;
        end
    end

    // refresh budget clamped to the legal span of writes per refresh
    wire logic [7:0] nv_limit =
        (nv_write_limit < NV_WRITES_MIN) ? NV_WRITES_MIN :
        (nv_write_limit > NV_WRITES_MAX) ? NV_WRITES_MAX :
        nv_write_limit;
    wire logic [7:0] nv_writes_inc = nv_writes_q + 8'h01;
    wire logic refresh_due = nv_write_done && (nv_writes_inc >= nv_limit);

    // counter saturates rather than wrapping back to a misleading low count
    assign nv_writes_d = refresh_due ? 8'h00 : nv_write_done ? nv_writes_inc : nv_writes_q;
    assign refresh_count_d = (refresh_due && (refresh_count_q != 16'hFFFF)) ?
                             refresh_count_q + 16'h0001 : refresh_count_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            nv_writes_q <= 8'h00;
            refresh_count_q <= RESET_REFRESH_COUNT;
            refresh_q <= 1'b0;
        end else begin
            nv_writes_q <= nv_writes_d;
            refresh_count_q <= refresh_count_d;
            refresh_q <= refresh_due;
        end
    end

    // feature flag registered so the output comes from a flip-flop
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            crypto_q <= 1'b0;
        end else begin
            crypto_q <= FW_MAJOR >= CRYPTO_MIN_MAJOR;
        end
    end

    assign tx_byte = tx_q;
    assign fault_notify_line = notify_q;
    assign ambient_req = ambient_req_q;
    assign ambient_channel = ambient_channel_q;
    assign nvm_refresh = refresh_q;
    assign encryption_en = crypto_q;

endmodule // status_identity_registers

`default_nettype wire
